/* File: clk_tone_ctrl.sv */
// Purpose: Clock configuration, tone table and path enable outputs.
// Assumes: Analog PLL and oscillator sit outside; this logic sets them.
// Notes: Converter strobe divides the chosen source by a settable ratio.
`default_nettype none
module clk_tone_ctrl (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_locked,
    input wire logic ref_tick,
    output logic ref_external_sel,
    output logic [7:0] pll_mult,
    output logic [7:0] ref_div,
    output logic conv_strobe,
    output logic tx_path_enable_out,
    output logic rx_path_enable_out
);
    import clk_tone_pkg::*;

    logic [15:0] tone_reg [16];
    logic [15:0] mode_reg;
    logic ref_sel_reg;
    logic [7:0] pll_mult_reg;
    logic [7:0] ref_div_reg;
    logic [7:0] conv_div_reg;
    logic conv_src_reg;
    logic [7:0] conv_cnt_reg;
    logic conv_strobe_reg;
    logic tx_en_reg;
    logic rx_en_reg;
    logic wr_en;
    logic rd_hit;
    logic [31:0] rd_data;
    logic conv_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding used by read and write paths
    function automatic logic is_tone(input logic [11:0] a);
        return a[11:6] == TONE_BASE_OFFSET[11:6];
    endfunction

    // Zero-wait APB slave
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Tone table, one word per slot, reset to the default set
    generate
        for (genvar s = 0; s < 16; s++) begin : g_tone
            // Slot word, rewritten only by a write to its own address
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    tone_reg[s] <= TONE_RESET[s];
                end else if (wr_en && is_tone(paddr) && paddr[5:2] == 4'(s)) begin
                    tone_reg[s] <= pwdata[15:0];
                end
            end

            // A write elsewhere leaves this slot alone
            tone_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
                !(wr_en && is_tone(paddr) && paddr[5:2] == 4'(s)) |=> $stable(tone_reg[s]))
                else $error("tone slot changed without a write");
        end
    endgenerate

    // Mode word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= 16'h0000;
        end else if (wr_en && paddr == MODE_OFFSET) begin
            mode_reg <= pwdata[15:0];
        end
    end

    // Clock configuration, defaults for the nominal crystal
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ref_sel_reg <= 1'b0;
            pll_mult_reg <= PLL_MULT_RESET;
            ref_div_reg <= REF_DIV_RESET;
            conv_div_reg <= CONV_DIV_RESET;
            conv_src_reg <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                REF_SEL_OFFSET: ref_sel_reg <= pwdata[0];
                PLL_MULT_OFFSET: pll_mult_reg <= pwdata[7:0];
                REF_DIV_OFFSET: ref_div_reg <= pwdata[7:0];
                CONV_DIV_OFFSET: conv_div_reg <= pwdata[7:0];
                CONV_SRC_OFFSET: conv_src_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Core clock = reference * mult / div, driven to the PLL
    assign pll_mult = pll_mult_reg;
    assign ref_div = ref_div_reg;
    assign ref_external_sel = ref_sel_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Converter strobe: divide core clock or reference tick
    assign conv_tick = conv_src_reg ? ref_tick : 1'b1;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            conv_cnt_reg <= 8'h00;
            conv_strobe_reg <= 1'b0;
        end else begin
            conv_strobe_reg <= 1'b0;
            if (conv_tick) begin
                if (conv_cnt_reg + 8'h01 >= conv_div_reg) begin
                    conv_cnt_reg <= 8'h00;
                    conv_strobe_reg <= 1'b1;
                end else begin
                    conv_cnt_reg <= conv_cnt_reg + 8'h01;
                end
            end
        end
    end
    assign conv_strobe = conv_strobe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Path enables, active low, two edges after the mode write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_en_reg <= 1'b1;
            rx_en_reg <= 1'b1;
        end else begin
            tx_en_reg <= ~(mode_reg[MODE_TX_BIT] & ~mode_reg[MODE_RX_BIT]);
            rx_en_reg <= ~(mode_reg[MODE_RX_BIT] & ~mode_reg[MODE_TX_BIT]);
        end
    end
    assign tx_path_enable_out = tx_en_reg;
    assign rx_path_enable_out = rx_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped reads as zero
    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (is_tone(paddr)) begin
            rd_data = {16'h0000, tone_reg[paddr[5:2]]};
        end else begin
            case (paddr)
                MODE_OFFSET: rd_data = {16'h0000, mode_reg};
                REF_SEL_OFFSET: rd_data = {31'h0, ref_sel_reg};
                PLL_MULT_OFFSET: rd_data = {24'h0, pll_mult_reg};
                REF_DIV_OFFSET: rd_data = {24'h0, ref_div_reg};
                CONV_DIV_OFFSET: rd_data = {24'h0, conv_div_reg};
                CONV_SRC_OFFSET: rd_data = {31'h0, conv_src_reg};
                STATUS_OFFSET: rd_data = {29'h0, pll_locked, rx_en_reg, tx_en_reg};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_hit ? rd_data : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the path enables

    // Transmit only pulls the transmit enable low
    tx_low_only_a: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_reg[MODE_TX_BIT] && !mode_reg[MODE_RX_BIT]) |=> !tx_path_enable_out)
        else $error("tx enable not low in tx mode");

    // Receive only pulls the receive enable low
    rx_low_only_a: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_reg[MODE_RX_BIT] && !mode_reg[MODE_TX_BIT]) |=> !rx_path_enable_out)
        else $error("rx enable not low in rx mode");

    // Idle and duplex keep both enables high
    both_high_a: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_reg[MODE_TX_BIT] == mode_reg[MODE_RX_BIT]) |=> (tx_path_enable_out && rx_path_enable_out))
        else $error("enable low in idle or duplex mode");

    // Transmit enable high outside transmit only
    tx_high_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(mode_reg[MODE_TX_BIT] && !mode_reg[MODE_RX_BIT]) |=> tx_path_enable_out)
        else $error("tx enable low outside tx mode");

    // Receive enable high outside receive only
    rx_high_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(mode_reg[MODE_RX_BIT] && !mode_reg[MODE_TX_BIT]) |=> rx_path_enable_out)
        else $error("rx enable low outside rx mode");

    // The two enables are never low together
    never_both_low_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(!tx_path_enable_out && !rx_path_enable_out))
        else $error("both enables low");

    // A receive mode write shows on the enable two edges later
    enable_follow_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == MODE_OFFSET && !pwdata[MODE_TX_BIT] && pwdata[MODE_RX_BIT]) |=> ##1 !rx_path_enable_out)
        else $error("rx enable late after mode write");

    // Mode word takes the written value
    mode_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == MODE_OFFSET) |=> mode_reg == $past(pwdata[15:0]))
        else $error("mode word not written");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the tone table and the clock words

    // Addressed tone slot takes the written value
    tone_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && is_tone(paddr)) |=> tone_reg[$past(paddr[5:2])] == $past(pwdata[15:0]))
        else $error("tone slot not written");

    // Multiplier reaches the PLL
    pll_cfg_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == PLL_MULT_OFFSET) |=> pll_mult == $past(pwdata[7:0]))
        else $error("pll multiplier not loaded");

    // Reference divider reaches the PLL
    ref_div_cfg_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == REF_DIV_OFFSET) |=> ref_div == $past(pwdata[7:0]))
        else $error("reference divider not loaded");

    // Reference source select reaches the oscillator
    ref_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == REF_SEL_OFFSET) |=> ref_external_sel == $past(pwdata[0]))
        else $error("reference select not loaded");

    // Converter ratio takes the written value
    conv_div_cfg_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == CONV_DIV_OFFSET) |=> conv_div_reg == $past(pwdata[7:0]))
        else $error("converter ratio not loaded");

    // Converter source takes the written value
    conv_src_cfg_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wr_en && paddr == CONV_SRC_OFFSET) |=> conv_src_reg == $past(pwdata[0]))
        else $error("converter source not loaded");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the converter strobe

    // Strobe lasts one cycle for ratios above one
    conv_strobe_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
        (conv_strobe && conv_div_reg > 8'h01) |=> !conv_strobe)
        else $error("converter strobe too long");

    // No reference tick, no strobe from the reference
    ref_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
        (conv_src_reg && !ref_tick) |=> !conv_strobe)
        else $error("strobe without reference tick");

    // Last count of a period fires the strobe
    strobe_count_a: assert property (@(posedge clock) disable iff (!arst_n)
        (conv_tick && conv_cnt_reg + 8'h01 >= conv_div_reg) |=> conv_strobe)
        else $error("strobe missing at end of period");

    // A zero ratio divides by one
    zero_ratio_a: assert property (@(posedge clock) disable iff (!arst_n)
        (conv_tick && conv_div_reg == 8'h00) |=> conv_strobe)
        else $error("zero ratio does not divide by one");

    // Counter holds between ticks
    tick_count_a: assert property (@(posedge clock) disable iff (!arst_n)
        !conv_tick |=> conv_cnt_reg == $past(conv_cnt_reg))
        else $error("counter moved without a tick");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the read path

    // Tone read returns the slot word
    tone_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (psel && !penable && !pwrite && is_tone(paddr)) |=> prdata == {16'h0000, $past(tone_reg[paddr[5:2]])})
        else $error("tone read data wrong");

    // Mode read returns the mode word
    mode_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (psel && !penable && !pwrite && paddr == MODE_OFFSET) |=> prdata == {16'h0000, $past(mode_reg)})
        else $error("mode read data wrong");

    // Status read returns lock and enables
    status_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (psel && !penable && !pwrite && paddr == STATUS_OFFSET)
        |=> prdata == {29'h0, $past(pll_locked), $past(rx_en_reg), $past(tx_en_reg)})
        else $error("status read data wrong");

    // Unmapped reads return zero
    unmapped_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (psel && !penable && !pwrite && !rd_hit) |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Read data stands until the next read setup
    read_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read");
endmodule
`default_nettype wire

/* File: clk_tone_pkg.sv */
// Purpose: Shared constants for the clock, tone table and path enable block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Tone table and clock words follow the program block layout.
`default_nettype none
package clk_tone_pkg;
    localparam logic [11:0] MODE_OFFSET = 12'h000;
    localparam logic [11:0] REF_SEL_OFFSET = 12'h004;
    localparam logic [11:0] PLL_MULT_OFFSET = 12'h008;
    localparam logic [11:0] REF_DIV_OFFSET = 12'h00C;
    localparam logic [11:0] CONV_DIV_OFFSET = 12'h010;
    localparam logic [11:0] CONV_SRC_OFFSET = 12'h014;
    localparam logic [11:0] STATUS_OFFSET = 12'h018;
    localparam logic [11:0] TONE_BASE_OFFSET = 12'h040;
    localparam int MODE_TX_BIT = 7;
    localparam int MODE_RX_BIT = 0;
    localparam int REF_KHZ_DEFAULT = 6144;
    localparam int XTAL_MAX_KHZ = 12288;
    localparam int EXT_MAX_KHZ = 24576;
    localparam int CORE_KHZ = 24576;
    localparam logic [7:0] PLL_MULT_RESET = 8'h04;
    localparam logic [7:0] REF_DIV_RESET = 8'h01;
    localparam logic [7:0] CONV_DIV_RESET = 8'h0C;
    localparam logic [15:0] TONE_RESET [16] = '{
        16'h07BD, 16'h0464, 16'h04AD, 16'h04FB, 16'h054E, 16'h05A6, 16'h0604, 16'h0668,
        16'h06D3, 16'h0744, 16'h0960, 16'h03A2, 16'h08C7, 16'h03DF, 16'h083E, 16'h041F};
endpackage
`default_nettype wire

/* File: ref_radio_model.sv */
// Purpose: Reference clock source and lock flag; the path enable inputs are not used.
// Assumes: One reference tick every four core cycles, a crystal at a quarter rate.
// Notes: Lock is reported a fixed time after reset.
`default_nettype none
module ref_radio_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic tx_path_enable_out,
    input wire logic rx_path_enable_out,
    output logic ref_tick,
    output logic pll_locked
);
    logic [1:0] div_reg;
    logic [5:0] lock_reg;
    // Reference ticks within crystal limits, lock after settling
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 2'h0;
            lock_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (lock_reg != 6'h3F) lock_reg <= lock_reg + 6'h01;
        end
    end
    // One tick pulse per reference period
    assign ref_tick = (div_reg == 2'h3);
    assign pll_locked = (lock_reg == 6'h3F);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for clock settings, tone table and path enables.
// Assumes: Zero wait APB slave, prdata loaded in setup cycle.
// Notes: Random data from a fixed seed.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import clk_tone_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, pll_locked, ref_tick, ref_external_sel, conv_strobe, tx, rx;
    logic [7:0] pll_mult, ref_div;
    int fail_count = 0, checks_done = 0, seed = 63819, n, i;
    clk_tone_ctrl dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_locked(pll_locked), .ref_tick(ref_tick), .ref_external_sel(ref_external_sel),
        .pll_mult(pll_mult), .ref_div(ref_div), .conv_strobe(conv_strobe),
        .tx_path_enable_out(tx), .rx_path_enable_out(rx));
    ref_radio_model partner (.clock(clock), .arst_n(arst_n), .tx_path_enable_out(tx),
        .rx_path_enable_out(rx), .ref_tick(ref_tick), .pll_locked(pll_locked));
    always #2 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock); penable <= 1'b1;
        @(posedge clock); while (pready !== 1'b1) @(posedge clock);
        rd = prdata; psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask
    // Cycles between two strobes
    task automatic gap(output int c);
        c = 0;
        @(posedge clock); while (conv_strobe !== 1'b1) @(posedge clock);
        do begin @(posedge clock); c++; end while (conv_strobe !== 1'b1);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        chk({tx, rx, ref_external_sel, pll_mult, ref_div}, {3'b110, PLL_MULT_RESET, REF_DIV_RESET});
        for (i = 0; i < 16; i++) begin
            apb(1'b0, TONE_BASE_OFFSET + 12'(4 * i), 32'h0);
            chk(rd, {16'h0, TONE_RESET[i]});
            v = $random(seed);
            apb(1'b1, TONE_BASE_OFFSET + 12'(4 * i), v);
            apb(1'b0, TONE_BASE_OFFSET + 12'(4 * i), 32'h0);
            chk(rd, {16'h0, v[15:0]});
        end
        apb(1'b1, TONE_BASE_OFFSET, 32'h0000_0258);
        apb(1'b1, TONE_BASE_OFFSET + 12'h03C, 32'h0);
        apb(1'b0, TONE_BASE_OFFSET, 32'h0);
        chk(rd, 32'h0000_0258);
        apb(1'b0, TONE_BASE_OFFSET + 12'h03C, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, TONE_BASE_OFFSET + 12'h040, v);
        apb(1'b0, TONE_BASE_OFFSET + 12'h040, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            apb(1'b1, MODE_OFFSET, {16'h0, v[15:8], i[1], v[6:1], i[0]});
            repeat (2) @(posedge clock);
            chk({tx, rx}, {~(i[1] & ~i[0]), ~(i[0] & ~i[1])});
        end
        v = $random(seed);
        apb(1'b1, REF_SEL_OFFSET, 32'h1);
        apb(1'b1, PLL_MULT_OFFSET, v);
        apb(1'b1, REF_DIV_OFFSET, v >> 8);
        @(posedge clock);
        chk({ref_external_sel, pll_mult, ref_div}, {1'b1, v[7:0], v[15:8]});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd[2], 1'b1);
        gap(n);
        chk(n, 12);
        apb(1'b1, CONV_SRC_OFFSET, 32'h1);
        apb(1'b1, CONV_DIV_OFFSET, 32'h3);
        gap(n);
        gap(n);
        chk(n, 12);
        wrap_up();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
